// ==== psg_consts.svh ====
/*
  Constants for the protection switch glue logic: register offsets,
  field positions and reset values.
  Assumes it is included by bare name wherever a number is needed.
*/
`ifndef PSG_CONSTS_SVH
`define PSG_CONSTS_SVH

// Register offsets on the plain register port
`define PSG_ADDR_W 4
`define PSG_OFF_ENABLE 4'h0
`define PSG_OFF_SERIAL 4'h1
`define PSG_OFF_CHIP 4'h2
`define PSG_OFF_AMP 4'h3
`define PSG_OFF_STATUS 4'h4

// Enable register fields
`define PSG_EN_TX_A 0
`define PSG_EN_TX_B 1
`define PSG_EN_RX_A 2
`define PSG_EN_RX_B 3
`define PSG_EN_IO_A 4
`define PSG_EN_IO_B 5

// Serial register fields
`define PSG_SER_DIR 4
`define PSG_SER_SEL_LSB 0
`define PSG_SER_SEL_MSB 3

// Amplifier register fields
`define PSG_AMP_CUT 0
`define PSG_AMP_BOOST 1

// Widths and reset values
`define PSG_CHIP_N 7
`define PSG_ENABLE_RST 6'h15
`define PSG_ZERO32 32'h0000_0000

`endif

// ==== psg_pkg.sv ====
/*
  Types shared by the protection switch glue logic.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package psg_pkg;
  // One side-pair function index
  typedef enum logic [1:0] {
    psg_fn_tx,
    psg_fn_rx,
    psg_fn_io
  } psg_func_t;
  // A/B pair of enables
  typedef struct packed {
    logic side_b;
    logic side_a;
  } psg_pair_t;
endpackage

// ==== psg_sel_if.sv ====
/*
  Interface carrying the module-select latch signals between the top
  and its serial select stage.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface psg_sel_if;
  logic [3:0] sel_sw;
  logic dir_sw;
  logic bus_clk;
  logic [3:0] sel_q;
  logic dir_q;
  modport ctl (output sel_sw, output dir_sw, output bus_clk, input sel_q, input dir_q);
  modport stage (input sel_sw, input dir_sw, input bus_clk, output sel_q, output dir_q);
endinterface

// ==== psg_side_pair.sv ====
/*
  One A/B side pair: software value, panel override, optional mutual
  exclusion that keeps the side now enabled on a conflict.
  Assumes synchronised inputs on clk.
*/
`timescale 1ns/1ps
module psg_side_pair #(
  parameter bit EXCLUSIVE = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Requests
  input psg_pkg::psg_pair_t sw_req,
  input wire logic force_req,
  input wire logic panel_a,
  // Output
  output psg_pkg::psg_pair_t en_out
);
  psg_pkg::psg_pair_t want;
  psg_pkg::psg_pair_t en_reg;
  psg_pkg::psg_pair_t en_next;

  // Choose source and resolve conflicts
  always_comb begin
    if (force_req) begin
      want.side_a = panel_a;
      want.side_b = ~panel_a;
    end else begin
      want = sw_req;
    end
    en_next = want;
    if (EXCLUSIVE && want.side_a && want.side_b) begin
      en_next = en_reg;
      if (en_reg.side_a && en_reg.side_b) begin
        en_next.side_b = 1'b0;
      end
    end
  end

  // Register the enables
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      en_reg <= '0;
    end else begin
      en_reg <= en_next;
    end
  end

  assign en_out = en_reg;
endmodule // psg_side_pair

// ==== psg_serial_sel.sv ====
/*
  Module-select and direction latch, loaded in each system clock
  cycle in which the serial bus clock pulse stands.
  Assumes bus_clk is a same-domain signal made by the top.
*/
`timescale 1ns/1ps
module psg_serial_sel (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Select stage
  psg_sel_if.stage sel
);
  logic [3:0] sel_reg;
  logic [3:0] sel_next;
  logic dir_reg;
  logic dir_next;

  // capture while bus clock pulse stands
  // Level capture lets back-to-back serial writes each land
  always_comb begin
    sel_next = sel_reg;
    dir_next = dir_reg;
    if (sel.bus_clk) begin
      sel_next = sel.sel_sw;
      dir_next = sel.dir_sw;
    end
  end

  // Register the latch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_reg <= 4'h0;
      dir_reg <= 1'b0;
    end else begin
      sel_reg <= sel_next;
      dir_reg <= dir_next;
    end
  end

  assign sel.sel_q = sel_reg;
  assign sel.dir_q = dir_reg;
endmodule // psg_serial_sel

// ==== psg_glue_top.sv ====
/*
  Protection switch glue logic top: side enables, module serial
  select, chip selects and amplifier controls, with a register port.
  Assumes panel, fitted and low-voltage inputs are asynchronous pins.
*/
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`include "psg_consts.svh"

// Overview of operation
// - Separate software-settable transmit, receive and I/O enables for sides A and B.
// - Panel receive-A with force sets receiver A online and clears B.
// - Never both receivers or both I/O sections online at once.
// - Enables follow software except under override, when panel switches drive.
// - Direction signal picks transmit or receive mode of module serial bus.
// - Four select lines address the module in a serial transfer.
// - Select lines are registered on the serial bus clock.
// - Seven chip-pick lines enable chips on the register data bus.
// - Processor is held in reset while supply is low, except for two cycles from the first clock after reset.
// - Power-cut output makes an external switch remove amplifier supply.
// - Bias-boost output asserted for high-power operation, else deasserted.
module psg_glue_top (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [`PSG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Front panel
  input wire logic manual_force,
  input wire logic [2:0] panel_side_a,
  // Side enables
  output logic transmitter_online_side_a,
  output logic transmitter_online_side_b,
  output logic receiver_online_side_a,
  output logic receiver_online_side_b,
  output logic io_online_side_a,
  output logic io_online_side_b,
  // Module serial bus
  output logic serial_direction_select,
  output logic [3:0] module_select,
  output logic serial_bus_clk,
  // Register data bus chip selects, active low
  input wire logic [`PSG_ADDR_W-1:0] periph_addr,
  input wire logic periph_strobe,
  output logic [`PSG_CHIP_N-1:0] chip_pick_lines_n,
  // Supply and amplifiers
  input wire logic supply_low,
  output logic cpu_reset_n,
  output logic amplifier_power_cut,
  output logic amplifier_bias_boost,
  // Presence of fitted modules
  input wire logic [1:0] transmitter_fitted,
  input wire logic [1:0] receiver_fitted,
  input wire logic [1:0] amplifier_fitted
);
  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  localparam int SYNC_W = 11;
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] pins;

  // Gather the asynchronous pins
  assign pin_raw = {supply_low, manual_force, panel_side_a, transmitter_fitted,
                    receiver_fitted, amplifier_fitted};

  // Two flops per pin; panel, presence and supply pins are asynchronous,
  // so nothing but the second stage reads the first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pin_raw;
      sync2_reg <= sync1_reg;
    end
  end
  assign pins = sync2_reg;

  logic low_s;
  logic force_s;
  logic [2:0] panel_s;
  logic [5:0] fitted_s;
  // Name the synchronised pin fields
  assign low_s = pins[10];
  assign force_s = pins[9];
  assign panel_s = pins[8:6];
  assign fitted_s = pins[5:0];

  ////////////////////////////////////////////////////////////////////
  // Software registers
  logic [5:0] enable_reg;
  logic [5:0] enable_next;
  logic [4:0] serial_reg;
  logic [4:0] serial_next;
  logic [`PSG_CHIP_N-1:0] chip_reg;
  logic [`PSG_CHIP_N-1:0] chip_next;
  logic [1:0] amp_reg;
  logic [1:0] amp_next;
  logic sclk_reg;
  logic sclk_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [5:0] online;
  logic [31:0] status_word;

  // Register write decode; serial write also toggles bus clock high
  always_comb begin
    enable_next = enable_reg;
    serial_next = serial_reg;
    chip_next = chip_reg;
    amp_next = amp_reg;
    // Bus clock is a one-cycle pulse after each serial write
    sclk_next = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        `PSG_OFF_ENABLE: begin
          enable_next = reg_wdata[5:0];
        end
        `PSG_OFF_SERIAL: begin
          serial_next = reg_wdata[4:0];
          sclk_next = 1'b1;
        end
        `PSG_OFF_CHIP: begin
          chip_next = reg_wdata[`PSG_CHIP_N-1:0];
        end
        `PSG_OFF_AMP: begin
          amp_next = reg_wdata[1:0];
        end
        // Status and unmapped offsets ignore writes
        default: begin
          enable_next = enable_reg;
        end
      endcase
    end
  end

  // Status word from synchronised pins and the live enables
  assign status_word = {15'h0, low_s, force_s, panel_s, fitted_s, online};

  // Read mux, data one cycle after strobe
  always_comb begin
    rdata_next = `PSG_ZERO32;
    if (reg_rd) begin
      unique case (reg_addr)
        `PSG_OFF_ENABLE: rdata_next = {26'h0, enable_reg};
        `PSG_OFF_SERIAL: rdata_next = {27'h0, serial_reg};
        `PSG_OFF_CHIP: rdata_next = {25'h0, chip_reg};
        `PSG_OFF_AMP: rdata_next = {30'h0, amp_reg};
        `PSG_OFF_STATUS: rdata_next = status_word;
        // Unmapped offsets read as zero
        default: rdata_next = `PSG_ZERO32;
      endcase
    end
  end

  // Register the software state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      enable_reg <= `PSG_ENABLE_RST;
      serial_reg <= 5'h00;
      chip_reg <= '0;
      amp_reg <= 2'h0;
      sclk_reg <= 1'b0;
      rdata_reg <= `PSG_ZERO32;
    end else begin
      enable_reg <= enable_next;
      serial_reg <= serial_next;
      chip_reg <= chip_next;
      amp_reg <= amp_next;
      sclk_reg <= sclk_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////
  // Side enable pairs
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pair
      psg_pkg::psg_pair_t req;
      psg_pkg::psg_pair_t en;
      assign req.side_a = enable_reg[2*g];
      assign req.side_b = enable_reg[2*g+1];
      // one pair per function
      // Transmit pair (g = 0) may run both sides; rx and io exclude
      psg_side_pair #(
        .EXCLUSIVE(g != 0)
      ) u_pair (
        .clk(clk),
        .reset_n(reset_n),
        .sw_req(req),
        .force_req(force_s),
        .panel_a(panel_s[g]),
        .en_out(en)
      );
      assign online[2*g] = en.side_a;
      assign online[2*g+1] = en.side_b;
    end
  endgenerate

  // Drive the six enable pins
  assign transmitter_online_side_a = online[`PSG_EN_TX_A];
  assign transmitter_online_side_b = online[`PSG_EN_TX_B];
  assign receiver_online_side_a = online[`PSG_EN_RX_A];
  assign receiver_online_side_b = online[`PSG_EN_RX_B];
  assign io_online_side_a = online[`PSG_EN_IO_A];
  assign io_online_side_b = online[`PSG_EN_IO_B];

  ////////////////////////////////////////////////////////////////////
  // Module serial select
  // Carrier between the top and the select stage
  psg_sel_if u_sel_if ();
  // Feed the select stage from the serial register and the pulse
  assign u_sel_if.sel_sw = serial_reg[`PSG_SER_SEL_MSB:`PSG_SER_SEL_LSB];
  assign u_sel_if.dir_sw = serial_reg[`PSG_SER_DIR];
  assign u_sel_if.bus_clk = sclk_reg;

  psg_serial_sel u_serial (
    .clk(clk),
    .reset_n(reset_n),
    .sel(u_sel_if.stage)
  );
  // Latched select, direction and bus clock pins
  assign module_select = u_sel_if.sel_q;
  assign serial_direction_select = u_sel_if.dir_q;
  assign serial_bus_clk = sclk_reg;

  ////////////////////////////////////////////////////////////////////
  // Chip selects
  logic [`PSG_CHIP_N-1:0] pick_reg;
  logic [`PSG_CHIP_N-1:0] pick_next;

  // decode address to one line
  // Disabled lines stay high whatever the address
  always_comb begin
    pick_next = '1;
    for (int i = 0; i < `PSG_CHIP_N; i++) begin
      if (periph_strobe && chip_reg[i] && (periph_addr == `PSG_ADDR_W'(i))) begin
        pick_next[i] = 1'b0;
      end
    end
  end

  // Register the picks; all lines idle high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pick_reg <= '1;
    end else begin
      pick_reg <= pick_next;
    end
  end
  assign chip_pick_lines_n = pick_reg;

  ////////////////////////////////////////////////////////////////////
  // Supply supervision and amplifier outputs
  logic cpu_rst_reg;
  logic cpu_rst_next;
  logic cut_reg;
  logic cut_next;
  logic boost_reg;
  logic boost_next;

  // hold processor in reset when low
  always_comb begin
    cpu_rst_next = ~low_s;
    cut_next = amp_reg[`PSG_AMP_CUT];
    // Boost is dropped while the supply feed is cut
    boost_next = amp_reg[`PSG_AMP_BOOST] & ~amp_reg[`PSG_AMP_CUT];
  end

  // Processor reset starts low and rises on the first clock after reset, before the supply pin has passed the synchronisers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rst_reg <= 1'b0;
      cut_reg <= 1'b0;
      boost_reg <= 1'b0;
    end else begin
      cpu_rst_reg <= cpu_rst_next;
      cut_reg <= cut_next;
      boost_reg <= boost_next;
    end
  end

  assign amplifier_power_cut = cut_reg;
  assign amplifier_bias_boost = boost_reg;
  assign cpu_reset_n = cpu_rst_reg;
endmodule // psg_glue_top

// ==== psg_glue_sva.sv ====
/* Port checker for psg_glue_top.
   Assumes it is bound onto that module by port name. */
`timescale 1ns/1ps
`include "psg_consts.svh"
module psg_glue_sva (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port and panel
  input wire logic [`PSG_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic manual_force,
  input wire logic [2:0] panel_side_a,
  // Side enables
  input wire logic transmitter_online_side_a,
  input wire logic transmitter_online_side_b,
  input wire logic receiver_online_side_a,
  input wire logic receiver_online_side_b,
  input wire logic io_online_side_a,
  input wire logic io_online_side_b,
  // Serial, chips, supply, amplifiers
  input wire logic serial_direction_select,
  input wire logic [3:0] module_select,
  input wire logic serial_bus_clk,
  input wire logic [`PSG_ADDR_W-1:0] periph_addr,
  input wire logic periph_strobe,
  input wire logic [`PSG_CHIP_N-1:0] chip_pick_lines_n,
  input wire logic supply_low,
  input wire logic cpu_reset_n,
  input wire logic amplifier_power_cut,
  input wire logic amplifier_bias_boost
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  ////////////////////////////////
  // Bus clock pulse, then select and direction loaded
  sequence s_ser_load;
    serial_bus_clk ##1 ({serial_direction_select, module_select} == $past(reg_wdata[4:0], 2));
  endsequence
  // Enable write with no override pending, two cycles on
  sequence s_en_wr;
    (!manual_force)[*3] ##1 (!manual_force && reg_wr && reg_addr == `PSG_OFF_ENABLE) ##2 1'b1;
  endsequence
  a_rx_one_side: assert property (!(receiver_online_side_a && receiver_online_side_b))
    else $error("both receivers online");
  a_io_one_side: assert property (!(io_online_side_a && io_online_side_b))
    else $error("both io sections online");
  a_force_rx_a: assert property ((manual_force && panel_side_a[1])[*5] |->
    receiver_online_side_a && !receiver_online_side_b) else $error("forced rx wrong");
  a_force_io_b: assert property ((manual_force && !panel_side_a[2])[*5] |->
    io_online_side_b && !io_online_side_a) else $error("forced io wrong");
  a_soft_tx: assert property (s_en_wr |->
    {transmitter_online_side_b, transmitter_online_side_a} == $past(reg_wdata[1:0], 2))
    else $error("tx enables not as written");
  a_serial_load: assert property (reg_wr && reg_addr == `PSG_OFF_SERIAL |=> s_ser_load)
    else $error("serial select not loaded");
  a_select_hold: assert property (
    $changed({serial_direction_select, module_select}) |-> $past(serial_bus_clk))
    else $error("select moved without bus clock");
  a_chip_one: assert property (chip_pick_lines_n != 7'h7f |-> $past(periph_strobe) &&
    chip_pick_lines_n == ~(7'h01 << $past(periph_addr))) else $error("wrong chip pick");
  a_cpu_hold: assert property (supply_low[*4] |-> !cpu_reset_n)
    else $error("cpu not held in reset");
  a_cut_boost: assert property (amplifier_power_cut |-> !amplifier_bias_boost)
    else $error("boost while power cut");
endmodule // psg_glue_sva
////////////////////////////////
bind psg_glue_top psg_glue_sva chk (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .manual_force(manual_force), .panel_side_a(panel_side_a),
  .transmitter_online_side_a(transmitter_online_side_a),
  .transmitter_online_side_b(transmitter_online_side_b),
  .receiver_online_side_a(receiver_online_side_a),
  .receiver_online_side_b(receiver_online_side_b),
  .io_online_side_a(io_online_side_a), .io_online_side_b(io_online_side_b),
  .serial_direction_select(serial_direction_select), .module_select(module_select),
  .serial_bus_clk(serial_bus_clk), .periph_addr(periph_addr), .periph_strobe(periph_strobe),
  .chip_pick_lines_n(chip_pick_lines_n), .supply_low(supply_low), .cpu_reset_n(cpu_reset_n),
  .amplifier_power_cut(amplifier_power_cut), .amplifier_bias_boost(amplifier_bias_boost)
);

// ==== psg_far_model.sv ====
/* Radio module side: presence levels and a select receiver latch.
   Assumes serial_bus_clk is a one-cycle pulse on clk. */
`timescale 1ns/1ps
module psg_far_model #(
  parameter logic [5:0] FIT = 6'h1b
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Module serial bus
  input wire logic serial_bus_clk,
  input wire logic [3:0] module_select,
  input wire logic serial_direction_select,
  output logic [4:0] held_sel,
  // Presence levels
  output logic [1:0] transmitter_fitted,
  output logic [1:0] receiver_fitted,
  output logic [1:0] amplifier_fitted
);
  logic pend;
  assign {transmitter_fitted, receiver_fitted, amplifier_fitted} = FIT;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend <= 1'b0;
      held_sel <= 5'h00;
    end else begin
      pend <= serial_bus_clk;
      if (pend) held_sel <= {serial_direction_select, module_select};
    end
  end
endmodule // psg_far_model

// ==== psg_glue_top_tb.sv ====
/* Self-checking bench for psg_glue_top.
   Assumes psg_far_model stands on the module side. */
`timescale 1ns/1ps
`include "psg_consts.svh"
module psg_glue_top_tb;
  logic clk, reset_n, reg_wr, reg_rd, manual_force, periph_strobe, supply_low;
  logic [3:0] reg_addr, periph_addr, module_select;
  logic [31:0] reg_wdata, reg_rdata;
  logic [2:0] panel_side_a;
  logic [6:0] chip_pick_lines_n;
  logic [4:0] held_sel;
  logic [1:0] transmitter_fitted, receiver_fitted, amplifier_fitted;
  logic transmitter_online_side_a, transmitter_online_side_b, receiver_online_side_a;
  logic receiver_online_side_b, io_online_side_a, io_online_side_b, serial_direction_select;
  logic serial_bus_clk, cpu_reset_n, amplifier_power_cut, amplifier_bias_boost;
  wire [5:0] en = {io_online_side_b, io_online_side_a, receiver_online_side_b,
    receiver_online_side_a, transmitter_online_side_b, transmitter_online_side_a};
  int errors, cmp_count;

  psg_glue_top uut (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .manual_force(manual_force),
    .panel_side_a(panel_side_a), .transmitter_online_side_a(transmitter_online_side_a),
    .transmitter_online_side_b(transmitter_online_side_b),
    .receiver_online_side_a(receiver_online_side_a),
    .receiver_online_side_b(receiver_online_side_b),
    .io_online_side_a(io_online_side_a), .io_online_side_b(io_online_side_b),
    .serial_direction_select(serial_direction_select), .module_select(module_select),
    .serial_bus_clk(serial_bus_clk), .periph_addr(periph_addr), .periph_strobe(periph_strobe),
    .chip_pick_lines_n(chip_pick_lines_n), .supply_low(supply_low), .cpu_reset_n(cpu_reset_n),
    .amplifier_power_cut(amplifier_power_cut), .amplifier_bias_boost(amplifier_bias_boost),
    .transmitter_fitted(transmitter_fitted), .receiver_fitted(receiver_fitted),
    .amplifier_fitted(amplifier_fitted)
  );
  psg_far_model far (
    .clk(clk), .reset_n(reset_n), .serial_bus_clk(serial_bus_clk),
    .module_select(module_select), .serial_direction_select(serial_direction_select),
    .held_sel(held_sel), .transmitter_fitted(transmitter_fitted),
    .receiver_fitted(receiver_fitted), .amplifier_fitted(amplifier_fitted)
  );
  ////////////////////////////////
  // Compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] want);
    cmp_count++;
    if (got !== want) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  // Wait, then sample settled outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Register write, strobe held for one cycle, returns as it drops
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Register read, data in the next cycle
  task automatic rd(input logic [3:0] a, input logic [31:0] want);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, want);
  endtask
  // One peripheral strobe
  task automatic pick(input logic [3:0] a, input logic [6:0] want);
    @(posedge clk);
    periph_addr <= a;
    periph_strobe <= 1'b1;
    @(posedge clk);
    periph_strobe <= 1'b0;
    #1 check({25'h0, chip_pick_lines_n}, {25'h0, want});
  endtask
  ////////////////////////////////
  task automatic t_reset();
    rd(`PSG_OFF_ENABLE, 32'h15);
    check({26'h0, en}, 32'h15);
    rd(4'hf, 32'h0);
    rd(`PSG_OFF_STATUS, {20'h0, 6'h1b, 6'h15});
    wr(`PSG_OFF_STATUS, 32'h3f);
    rd(`PSG_OFF_ENABLE, 32'h15);
  endtask
  task automatic t_soft();
    logic [5:0] req [5] = '{6'h03, 6'h2a, 6'h3f, 6'h15, 6'h3c};
    logic [5:0] want [5] = '{6'h03, 6'h2a, 6'h2b, 6'h15, 6'h14};
    foreach (req[i]) begin
      wr(`PSG_OFF_ENABLE, {26'h0, req[i]});
      cyc(3);
      check({26'h0, en}, {26'h0, want[i]});
    end
  endtask
  task automatic t_force();
    @(posedge clk);
    manual_force <= 1'b1;
    panel_side_a <= 3'b010;
    cyc(5);
    check({26'h0, en}, 32'h26);
    @(posedge clk);
    panel_side_a <= 3'b101;
    wr(`PSG_OFF_ENABLE, 32'h2a);
    cyc(5);
    check({26'h0, en}, 32'h19);
    @(posedge clk);
    manual_force <= 1'b0;
    cyc(5);
    check({26'h0, en}, 32'h2a);
  endtask
  task automatic t_serial();
    for (int i = 0; i < 4; i++) begin
      logic [31:0] v;
      v = {27'h0, i[0], 4'h1 << i};
      wr(`PSG_OFF_SERIAL, v);
      #1 check({31'h0, serial_bus_clk}, 32'h1);
      cyc(3);
      check({31'h0, serial_bus_clk}, 32'h0);
      check({27'h0, serial_direction_select, module_select}, v);
      check({27'h0, held_sel}, v);
    end
    // Back-to-back select writes, the second must land
    @(posedge clk);
    reg_addr <= `PSG_OFF_SERIAL;
    reg_wdata <= 32'h0000_0005;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wdata <= 32'h0000_001a;
    @(posedge clk);
    reg_wr <= 1'b0;
    cyc(3);
    check({27'h0, serial_direction_select, module_select}, 32'h1a);
    check({27'h0, held_sel}, 32'h1a);
  endtask
  task automatic t_chip();
    wr(`PSG_OFF_CHIP, 32'h7f);
    for (int i = 0; i < 8; i++) pick(4'(i), ~(7'h01 << i));
    wr(`PSG_OFF_CHIP, 32'h7e);
    pick(4'h0, 7'h7f);
    pick(4'h1, 7'h7d);
  endtask
  task automatic t_amp();
    logic [1:0] w [3] = '{2'h1, 2'h2, 2'h3};
    foreach (w[i]) begin
      wr(`PSG_OFF_AMP, {30'h0, w[i]});
      cyc(2);
      check({30'h0, amplifier_bias_boost, amplifier_power_cut},
        {30'h0, w[i] == 2'h3 ? 2'h1 : w[i]});
    end
  endtask
  task automatic t_supply();
    @(posedge clk);
    supply_low <= 1'b1;
    cyc(5);
    check({31'h0, cpu_reset_n}, 32'h0);
    @(posedge clk);
    supply_low <= 1'b0;
    cyc(5);
    check({31'h0, cpu_reset_n}, 32'h1);
  endtask
  // Verdict and end of run
  task automatic conclude();
    $display("errors %0d compares %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Main sequence
  initial begin
    {reset_n, reg_wr, reg_rd, manual_force, periph_strobe, supply_low} = 6'h00;
    {reg_addr, periph_addr, panel_side_a, reg_wdata} = 43'h0;
    errors = 0;
    cmp_count = 0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    cyc(4);
    t_reset();
    t_soft();
    t_force();
    t_serial();
    t_chip();
    t_amp();
    t_supply();
    conclude();
  end
  // Watchdog
  initial begin
    #20000;
    errors++;
    conclude();
  end
endmodule // psg_glue_top_tb
